// ==== bench/hps_regs_properties.sv ====
// concurrent checks on the ports of the hot-plug/smbus register slice
// assumes: one clock, active-high async reset, bound to hps_regs_top
module hps_regs_properties (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // apb
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // loader
    input wire logic EE_ERR_I,
    input wire logic EE_DONE_I,
    input wire logic EE_ABORT_O,
    input wire logic HALT_AFTER_RESET_SET_O,
    // slot and interrupt
    input wire logic SLOT_PWR_REQ_I,
    input wire logic SLOT_PWR_EN_O,
    input wire logic SLOT_RST_N_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // what may raise the interrupt
    wire logic irq_cause = EE_ERR_I || EE_DONE_I || (PREADY_O && PWRITE_I);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    // ==========================================================
    // bus: one wait state, one-cycle answers
    property p_ready_wait; PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("late bus answer");
    property p_ready_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_err_ready; PSLVERR_O |-> PREADY_O; endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray slverr");
    property p_rdata_idle; !PREADY_O |-> PRDATA_O == 32'h0000_0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    // ==========================================================
    // loader error aborts and halts next cycle, only then
    property p_abort; EE_ERR_I |=> EE_ABORT_O && HALT_AFTER_RESET_SET_O; endproperty
    a_abort: assert property (p_abort) else $error("no abort after error");
    property p_abort_cause; EE_ABORT_O || HALT_AFTER_RESET_SET_O |-> $past(EE_ERR_I);
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort without error");
    // ==========================================================
    // slot: reset held without power, dropped on request loss
    property p_rst_with_pwr; !SLOT_PWR_EN_O |-> !SLOT_RST_N_O; endproperty
    a_rst_with_pwr: assert property (p_rst_with_pwr) else $error("reset free, no power");
    property p_rise_pwr; $rose(SLOT_RST_N_O) |-> $past(SLOT_PWR_EN_O); endproperty
    a_rise_pwr: assert property (p_rise_pwr) else $error("reset freed early");
    property p_rst_drop; $fell(SLOT_PWR_REQ_I) && SLOT_RST_N_O |-> ##[1:3] !SLOT_RST_N_O;
    endproperty
    a_rst_drop: assert property (p_rst_drop) else $error("reset not reasserted");
    // interrupt only rises after an event or a register write
    property p_irq_cause; $rose(IRQ_O) |-> $past(irq_cause) || $past(irq_cause, 2); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule

bind hps_regs_top hps_regs_properties u_props (
    .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .EE_ERR_I(EE_ERR_I),
    .EE_DONE_I(EE_DONE_I), .EE_ABORT_O(EE_ABORT_O),
    .HALT_AFTER_RESET_SET_O(HALT_AFTER_RESET_SET_O), .SLOT_PWR_REQ_I(SLOT_PWR_REQ_I),
    .SLOT_PWR_EN_O(SLOT_PWR_EN_O), .SLOT_RST_N_O(SLOT_RST_N_O), .IRQ_O(IRQ_O));

// ==== bench/testbench.sv ====
// self-checking bench for the hot-plug/smbus register slice
// assumes: hps_cfg.svh on the include path
`include "hps_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICKS = 10; // short delay unit keeps the run brief
    // ==========================================================
    // design inputs, outputs and bench state
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, base, e, d;
    logic [6:0] taddr = 7'h00, caddr = 7'h00;
    logic ee_err = 1'b0, ee_done = 1'b0, req = 1'b0, good = 1'b0;
    logic [5:0] ee_kind = 6'h00;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, ee_abort, halt_set, pwr_en, rst_n, irq;
    logic [33:0] exp_q[$]; // {is read, slverr, read data}
    logic [33:0] e_mon;
    int n_mismatch = 0, samples_checked = 0, n;
    integer seed = 32'hdff06908;
    int kb[6] = '{21, 23, 25, 27, 28, 31}; // status bit of each error kind

    hps_regs_top #(.TICK_CYCLES(TICKS)) uut (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .TARGET_ADDR_PIN_I(taddr),
        .CONTROLLER_ADDR_PIN_I(caddr), .EE_ERR_I(ee_err), .EE_ERR_KIND_I(ee_kind),
        .EE_DONE_I(ee_done), .EE_ABORT_O(ee_abort), .HALT_AFTER_RESET_SET_O(halt_set),
        .SLOT_PWR_REQ_I(req), .SLOT_PWR_GOOD_I(good), .SLOT_PWR_EN_O(pwr_en),
        .SLOT_RST_N_O(rst_n), .IRQ_O(irq));

    initial forever #5 clk = ~clk;

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    // one apb transfer, waiting for pready
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       input logic [33:0] ex);
        @(posedge clk);
        exp_q.push_back(ex);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000, {2'b10, ex});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, {2'b00, 32'h0000_0000});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // monitor: each bus answer is matched to the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0)
                chk(1'b1, 1'b0);
            else begin
                e_mon = exp_q.pop_front();
                chk(pslverr, e_mon[32]);
                if (e_mon[33])
                    chk(prdata, e_mon[31:0]);
            end
        end
    end

    // watchdog: the run takes a few hundred cycles
    initial begin
        wt(20000);
        n_mismatch++;
        test_done();
    end

    // ==========================================================
    // main sequence
    initial begin
        taddr = 7'($random(seed));
        caddr = 7'($random(seed));
        base = {16'h0000, caddr, 1'b0, taddr, 1'b0};
        wt(20);
        rst <= 1'b0;
        wt(4); // straps need a few edges to be captured
        rd(`HPS_OFF_HOTPLUG_CFG, `HPS_RST_HP_CFG);
        rd(`HPS_OFF_SMBUS_STS, base);
        wr(`HPS_OFF_SMBUS_STS, 32'hFFFF_FFFF);
        rd(`HPS_OFF_SMBUS_STS, base);
        d = $random(seed);
        wr(`HPS_OFF_HOTPLUG_CFG, d);
        rd(`HPS_OFF_HOTPLUG_CFG, d);
        apb(1'b0, 16'h1190, 32'h0000_0000, {2'b11, 32'h0000_0000});
        apb(1'b1, 16'h1190, 32'hFFFF_FFFF, {2'b01, 32'h0000_0000});
        // unknown error first, then every known kind; interrupts masked
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            ee_err <= 1'b1;
            ee_kind <= (k == 0) ? 6'h00 : 6'(1 << (k - 1));
            @(posedge clk);
            ee_err <= 1'b0;
            ee_kind <= 6'($random(seed)); // ignored without the strobe
            e = base | 32'h0110_0000;
            if (k > 0)
                e[kb[k - 1]] = 1'b1;
            rd(`HPS_OFF_SMBUS_STS, e);
            wr(`HPS_OFF_SMBUS_STS, 32'hFFFF_FFFF);
            rd(`HPS_OFF_SMBUS_STS, base);
        end
        chk(irq, 1'b0);
        rd(`HPS_OFF_IRQ_STS, 32'h0000_0003);
        wr(`HPS_OFF_IRQ_MASK, 32'hFFFF_FFFF);
        rd(`HPS_OFF_IRQ_MASK, 32'h0000_0003);
        wt(2);
        chk(irq, 1'b1);
        wr(`HPS_OFF_IRQ_STS, 32'h0000_0001);
        wt(2);
        chk(irq, 1'b1);
        wr(`HPS_OFF_IRQ_STS, 32'h0000_0002);
        wt(2);
        chk(irq, 1'b0);
        // clean completion sets only the finished flag
        @(posedge clk);
        ee_done <= 1'b1;
        @(posedge clk);
        ee_done <= 1'b0;
        rd(`HPS_OFF_SMBUS_STS, base | 32'h0100_0000);
        chk(irq, 1'b1);
        wr(`HPS_OFF_IRQ_STS, 32'h0000_0003);
        // every reset mode code, no delays; reserved codes act like code 0
        for (int m = 0; m < 4; m++) begin
            wr(`HPS_OFF_HOTPLUG_CFG, {16'h0000, 2'(m), 14'h0000});
            @(posedge clk);
            req <= 1'b1;
            wt(12);
            chk(rst_n, (m == 1) ? 1'b0 : 1'b1);
            chk(pwr_en, 1'b1);
            good <= 1'b1;
            wt(8);
            chk(rst_n, 1'b1);
            req <= 1'b0;
            good <= 1'b0;
            wt(8);
            chk(pwr_en, 1'b0);
        end
        // two units before reset release, one unit before power drops
        wr(`HPS_OFF_HOTPLUG_CFG, 32'h0102_0000);
        @(posedge clk);
        req <= 1'b1;
        for (n = 0; n == 0 || (rst_n !== 1'b1 && n < 60); n++) @(posedge clk);
        chk(n >= 2 * TICKS && n <= 2 * TICKS + 12, 1'b1);
        req <= 1'b0;
        for (n = 0; n == 0 || (pwr_en !== 1'b0 && n < 60); n++) @(posedge clk);
        chk(n >= TICKS && n <= TICKS + 8, 1'b1);
        wt(4);
        test_done();
    end
endmodule

// ==== design/hps_regs_top.sv ====
// hot-plug configuration and smbus status registers with slot sequencing
// assumes: apb master on CLK_SYS_I, eeprom loader strobes on the same clock,
// address straps and slot power good arrive from pins
//
// Decided for this implementation: the APB slave port.
`include "hps_cfg.svh"

// What this block does
// - reset follows power enable or power good
// - release reset after power-to-reset delay
// - both delay fields reset to 0x14
// - drop power after reset-to-power-off delay
// - read-only target bus address field
// - read-only controller bus address field
// - load error flag set, cleared by one
// - load error aborts loading, sets halt
// - known error also sets its type bit
// - unknown error sets only general and finished flags
// - finished flag on completion or abort
module hps_regs_top #(
    parameter int unsigned TICK_CYCLES = `HPS_TICK_CYCLES
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [15:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // address straps from pins
    input wire logic [6:0] TARGET_ADDR_PIN_I,
    input wire logic [6:0] CONTROLLER_ADDR_PIN_I,
    // eeprom loader
    input wire logic EE_ERR_I,
    input wire logic [5:0] EE_ERR_KIND_I,
    input wire logic EE_DONE_I,
    output logic EE_ABORT_O,
    output logic HALT_AFTER_RESET_SET_O,
    // downstream slot
    input wire logic SLOT_PWR_REQ_I,
    input wire logic SLOT_PWR_GOOD_I,
    output logic SLOT_PWR_EN_O,
    output logic SLOT_RST_N_O,
    // interrupt
    output logic IRQ_O
);
    // ==========================================================
    // helpers
    // one-hot register hit: {irq_mask, irq_sts, smbus_status, hotplug_config_control}
    function automatic logic [3:0] reg_hit(input logic [15:0] a);
        reg_hit = {a == `HPS_OFF_IRQ_MASK, a == `HPS_OFF_IRQ_STS,
                   a == `HPS_OFF_SMBUS_STS, a == `HPS_OFF_HOTPLUG_CFG};
    endfunction

    // sticky update: hardware set wins over a write-one clear in the same cycle
    function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] set,
                                        input logic [31:0] clr);
        w1c = (cur & ~clr) | set;
    endfunction

    // known error kinds onto their status bits
    function automatic logic [31:0] kind_bits(input hps_pkg::hps_err_kind_s k);
        kind_bits = '0;
        kind_bits[`HPS_B_BAD_BLOCK] = k.bad_block;
        kind_bits[`HPS_B_ROLLOVER] = k.rollover;
        kind_bits[`HPS_B_NO_ACK] = k.no_ack;
        kind_bits[`HPS_B_OTHER] = k.other;
        kind_bits[`HPS_B_CHECKSUM] = k.checksum;
        kind_bits[`HPS_B_WAIT_TMO] = k.wait_tmo;
    endfunction

    // ==========================================================
    // declarations
    hps_pkg::hps_apb_req_s req; // bundled request
    hps_pkg::hps_err_kind_s kind; // error kind strobes
    logic [3:0] hit; // decoded register
    logic xfer; // apb completion edge
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] rd_val; // selected read value

    logic [31:0] hp_cfg; // hot-plug configuration control
    logic [31:0] next_hp_cfg;
    logic [31:0] sts_flags; // sticky flags of smbus status
    logic [31:0] next_sts_flags;
    logic [31:0] sts_set; // flags raised this cycle
    logic [31:0] sts_clr; // flags cleared by software
    logic [31:0] smbus_sts; // full status read value
    logic [1:0] irq_sts; // interrupt status
    logic [1:0] next_irq_sts;
    logic [1:0] irq_mask; // interrupt mask
    logic [1:0] next_irq_mask;
    logic [1:0] irq_set;
    logic next_irq;
    logic next_abort;

    logic [13:0] taddr_s1; // strap synchroniser, first stage
    logic [13:0] taddr_s2; // second stage
    logic [6:0] target_addr; // latched target bus address
    logic [6:0] controller_addr; // latched controller bus address
    logic [6:0] next_target_addr;
    logic [6:0] next_controller_addr;
    logic [1:0] strap_cnt; // edges since reset release
    logic [1:0] next_strap_cnt;
    logic strap_done; // straps captured
    logic next_strap_done;

    logic pg_s1; // power good synchroniser, first stage
    logic pg_s2; // second stage
    logic tick; // delay-unit tick
    logic tick_clr;

    assign req = '{addr: PADDR_I, write: PWRITE_I, wdata: PWDATA_I};
    assign kind = hps_pkg::hps_err_kind_s'(EE_ERR_KIND_I);
    assign hit = reg_hit(req.addr);
    assign xfer = PSEL_I & PENABLE_I & PREADY_O;

    // ==========================================================
    // apb slave: one wait state, every answer from a flop
    always_comb begin
        rd_val = '0;
        case (hit)
            4'h1: rd_val = hp_cfg;
            4'h2: rd_val = smbus_sts;
            4'h4: rd_val = {30'h0000_0000, irq_sts};
            4'h8: rd_val = {30'h0000_0000, irq_mask};
            default: rd_val = '0; // unmapped reads zero
        endcase
        next_pready = PSEL_I & PENABLE_I & ~PREADY_O;
        next_prdata = next_pready ? rd_val : '0;
        next_pslverr = next_pready & (hit == 4'h0); // unmapped address errors
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= '0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= next_pready;
            PRDATA_O <= next_prdata;
            PSLVERR_O <= next_pslverr;
        end
    end

    // ==========================================================
    // hot-plug configuration: plain read/write storage
    always_comb begin
        next_hp_cfg = hp_cfg;
        if (xfer && req.write && hit[0]) begin
            next_hp_cfg = req.wdata;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            hp_cfg <= `HPS_RST_HP_CFG;
        end else begin
            hp_cfg <= next_hp_cfg;
        end
    end

    // ==========================================================
    // smbus status flags and loader reactions
    always_comb begin
        sts_set = '0;
        if (EE_ERR_I) begin
            sts_set[`HPS_B_LOAD_ERR] = 1'b1;
            // an all-zero kind is an unknown error: general and finished flags only
            sts_set = sts_set | kind_bits(kind);
            sts_set[`HPS_B_DONE] = 1'b1;
        end
        if (EE_DONE_I) begin
            sts_set[`HPS_B_DONE] = 1'b1;
        end
        sts_clr = '0;
        if (xfer && req.write && hit[1]) begin
            sts_clr = req.wdata;
        end
        // only the sticky bits are ever stored
        next_sts_flags = w1c(sts_flags, sts_set, sts_clr) & `HPS_STS_W1C_MASK;
        next_abort = EE_ERR_I;
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sts_flags <= '0;
            EE_ABORT_O <= 1'b0;
            HALT_AFTER_RESET_SET_O <= 1'b0;
        end else begin
            sts_flags <= next_sts_flags;
            EE_ABORT_O <= next_abort;
            HALT_AFTER_RESET_SET_O <= next_abort;
        end
    end

    // reserved bits 0, 8 and 19:16 are constant zero here
    always_comb begin
        smbus_sts = sts_flags;
        smbus_sts[`HPS_F_TADDR_LSB +: 7] = target_addr;
        smbus_sts[`HPS_F_CADDR_LSB +: 7] = controller_addr;
    end

    // ==========================================================
    // address straps: synchronised, captured once after reset release
    always_comb begin
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;
        next_target_addr = target_addr;
        next_controller_addr = controller_addr;
        if (!strap_done) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == `HPS_STRAP_WAIT) begin
                // software writes never reach these fields
                next_target_addr = taddr_s2[6:0];
                next_controller_addr = taddr_s2[13:7];
                next_strap_done = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            taddr_s1 <= '0;
            taddr_s2 <= '0;
            strap_cnt <= '0;
            strap_done <= 1'b0;
            target_addr <= '0;
            controller_addr <= '0;
        end else begin
            taddr_s1 <= {CONTROLLER_ADDR_PIN_I, TARGET_ADDR_PIN_I};
            taddr_s2 <= taddr_s1;
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
            target_addr <= next_target_addr;
            controller_addr <= next_controller_addr;
        end
    end

    // ==========================================================
    // interrupt: sticky events, mask, one level output
    always_comb begin
        irq_set = '0;
        irq_set[`HPS_IRQ_ERR] = EE_ERR_I;
        irq_set[`HPS_IRQ_DONE] = EE_ERR_I | EE_DONE_I;
        next_irq_sts = irq_sts | irq_set;
        next_irq_mask = irq_mask;
        if (xfer && req.write && hit[2]) begin
            next_irq_sts = (irq_sts & ~req.wdata[1:0]) | irq_set;
        end
        if (xfer && req.write && hit[3]) begin
            next_irq_mask = req.wdata[1:0];
        end
        // computed from next values so the output tracks the bits without lag
        next_irq = |(next_irq_sts & next_irq_mask);
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_sts <= '0;
            irq_mask <= '0;
            IRQ_O <= 1'b0;
        end else begin
            irq_sts <= next_irq_sts;
            irq_mask <= next_irq_mask;
            IRQ_O <= next_irq;
        end
    end

    // ==========================================================
    // slot sequencing
    // power good is a pin: two flops before the sequencer reads it
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pg_s1 <= 1'b0;
            pg_s2 <= 1'b0;
        end else begin
            pg_s1 <= SLOT_PWR_GOOD_I;
            pg_s2 <= pg_s1;
        end
    end

    hps_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .clear_i(tick_clr),
        .tick_o(tick)
    );

    hps_slot_seq u_seq (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .mode_i(hp_cfg[`HPS_F_MODE_LSB +: 2]),
        .p2r_i(hp_cfg[`HPS_F_P2R_LSB +: 8]),
        .r2p_i(hp_cfg[`HPS_F_R2P_LSB +: 8]),
        .pwr_req_i(SLOT_PWR_REQ_I),
        .pwr_good_i(pg_s2),
        .tick_i(tick),
        .tick_clr_o(tick_clr),
        .slot_pwr_o(SLOT_PWR_EN_O),
        .slot_rst_n_o(SLOT_RST_N_O)
    );
endmodule

// ==== design/hps_slot_seq.sv ====
// downstream slot power/reset sequencer
// assumes: power good already synchronised, tick from hps_tick_gen
`include "hps_cfg.svh"
module hps_slot_seq (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic [1:0] mode_i,
    input wire hps_pkg::hps_delay_t p2r_i,
    input wire hps_pkg::hps_delay_t r2p_i,
    // slot inputs
    input wire logic pwr_req_i,
    input wire logic pwr_good_i,
    // tick handshake
    input wire logic tick_i,
    output logic tick_clr_o,
    // slot outputs
    output logic slot_pwr_o,
    output logic slot_rst_n_o
);
    hps_pkg::hps_slot_state_e state; // current phase
    hps_pkg::hps_slot_state_e next_state;
    hps_pkg::hps_delay_t cnt; // delay units elapsed
    hps_pkg::hps_delay_t next_cnt;
    logic stable; // power counts as stable

    // reserved modes fall back to power-enable control
    assign stable = (mode_i == `HPS_MODE_PGC) ? pwr_good_i : 1'b1;

    // ==========================================================
    // next phase
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        tick_clr_o = 1'b0;
        case (state)
            hps_pkg::SLOT_OFF: begin
                if (pwr_req_i) begin
                    next_state = hps_pkg::SLOT_WAIT;
                end
            end
            hps_pkg::SLOT_WAIT: begin
                if (!pwr_req_i) begin
                    // reset held low in this phase, no off delay owed
                    next_state = hps_pkg::SLOT_OFF;
                end else if (stable) begin
                    next_cnt = '0;
                    tick_clr_o = 1'b1;
                    next_state = (p2r_i == '0) ? hps_pkg::SLOT_ON
                                                : hps_pkg::SLOT_DLY_ON;
                end
            end
            hps_pkg::SLOT_DLY_ON: begin
                if (!pwr_req_i) begin
                    next_state = hps_pkg::SLOT_OFF;
                end else if (!stable) begin
                    next_state = hps_pkg::SLOT_WAIT;
                end else if (tick_i) begin
                    next_cnt = cnt + 8'h01;
                    if (next_cnt == p2r_i) begin
                        next_state = hps_pkg::SLOT_ON;
                    end
                end
            end
            hps_pkg::SLOT_ON: begin
                if (!pwr_req_i) begin
                    next_cnt = '0;
                    tick_clr_o = 1'b1;
                    next_state = (r2p_i == '0) ? hps_pkg::SLOT_OFF
                                                : hps_pkg::SLOT_DLY_OFF;
                end else if (!stable) begin
                    next_state = hps_pkg::SLOT_WAIT;
                end
            end
            hps_pkg::SLOT_DLY_OFF: begin
                // the off delay always runs to its end
                if (tick_i) begin
                    next_cnt = cnt + 8'h01;
                    if (next_cnt == r2p_i) begin
                        next_state = hps_pkg::SLOT_OFF;
                    end
                end
            end
            default: begin
                next_state = hps_pkg::SLOT_OFF;
            end
        endcase
    end

    // ==========================================================
    // outputs registered from the next phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= hps_pkg::SLOT_OFF;
            cnt <= '0;
            slot_pwr_o <= 1'b0;
            slot_rst_n_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            slot_pwr_o <= (next_state != hps_pkg::SLOT_OFF);
            slot_rst_n_o <= (next_state == hps_pkg::SLOT_ON);
        end
    end
endmodule

// ==== design/hps_tick_gen.sv ====
// delay-unit tick generator for the slot sequencer
// assumes: clear comes from logic on the same clock
module hps_tick_gen #(
    parameter int unsigned TICK_CYCLES = 1000000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clear_i,
    // tick out
    output logic tick_o
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cnt; // cycles since last tick or clear
    logic [CW-1:0] next_cnt;
    logic next_tick;

    // ==========================================================
    // restart on clear so a delay is a whole number of units, not one less
    always_comb begin
        next_cnt = cnt + CW'(1);
        next_tick = 1'b0;
        if (clear_i) begin
            next_cnt = '0;
        end else if (cnt == LAST) begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule

// ==== shared/hps_cfg.svh ====
// offsets, field positions, reset values and timing counts of the hot-plug/smbus slice
// assumes: byte addresses on a 32-bit apb bus, one 100 MHz system clock
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH

// ==========================================================
// register byte offsets
`define HPS_OFF_HOTPLUG_CFG 16'h117C
`define HPS_OFF_SMBUS_STS 16'h1188
`define HPS_OFF_IRQ_STS 16'h11A0
`define HPS_OFF_IRQ_MASK 16'h11A4

// ==========================================================
// field positions
`define HPS_F_MODE_LSB 14
`define HPS_F_P2R_LSB 16
`define HPS_F_R2P_LSB 24
`define HPS_F_TADDR_LSB 1
`define HPS_F_CADDR_LSB 9
`define HPS_B_LOAD_ERR 20
`define HPS_B_BAD_BLOCK 21
`define HPS_B_ROLLOVER 23
`define HPS_B_DONE 24
`define HPS_B_NO_ACK 25
`define HPS_B_OTHER 27
`define HPS_B_CHECKSUM 28
`define HPS_B_WAIT_TMO 31
`define HPS_STS_W1C_MASK 32'h9BB0_0000
`define HPS_IRQ_ERR 0
`define HPS_IRQ_DONE 1

// ==========================================================
// reset values and codes
`define HPS_RST_HP_CFG 32'h1414_0800
`define HPS_MODE_PEC 2'h0
`define HPS_MODE_PGC 2'h1
`define HPS_STRAP_WAIT 2'h2

// ==========================================================
// timing: delay unit in ms, clock in MHz, cycles per delay unit
`define HPS_CLK_MHZ 100
`define HPS_DELAY_UNIT_MS 10
`define HPS_TICK_CYCLES (`HPS_DELAY_UNIT_MS * 1000 * `HPS_CLK_MHZ)

`endif

// ==== shared/hps_pkg.sv ====
// types shared by the hot-plug/smbus register slice
// assumes: constants come from hps_cfg.svh
package hps_pkg;
    // ==========================================================
    // apb request as seen by the slave
    typedef struct packed {
        logic [15:0] addr;
        logic write;
        logic [31:0] wdata;
    } hps_apb_req_s;

    // known eeprom load error kinds, one bit each
    typedef struct packed {
        logic wait_tmo;
        logic checksum;
        logic other;
        logic no_ack;
        logic rollover;
        logic bad_block;
    } hps_err_kind_s;

    // slot sequencer states, one-hot
    typedef enum logic [4:0] {
        SLOT_OFF = 5'b00001,
        SLOT_WAIT = 5'b00010,
        SLOT_DLY_ON = 5'b00100,
        SLOT_ON = 5'b01000,
        SLOT_DLY_OFF = 5'b10000
    } hps_slot_state_e;

    typedef logic [7:0] hps_delay_t;
endpackage
